// ==== logic/display_bus_interface_glue.sv ====
`timescale 1ns/1ps

// Functional notes
// - secondary-red enable high grounds CRT line; low passes secondary red.
// - port range select high decodes 3XX, low decodes 2XX; a hit needs address bit 8 equal to it.
// - while address-output enable low, drive system address onto plane-3 lines.
// - 8-bit bidirectional local data bus shared with controller, ROM and SRAM.
// - dedicated plasma panel data outputs are active low.
// - CRT mode routes video to CRT; plasma mode carries syncs, data, selects.
// - accept 20-bit system address; 8-bit bidirectional system data.
// - provide trap request output and separate NMI timing output.
// - panel-select input chooses CRT or plasma routing.
module display_bus_interface_glue (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [19:0] i_sys_addr,
  input wire logic [7:0] i_sys_data,
  output logic [7:0] o_sys_data,
  output logic o_sys_data_oe_n,
  input wire logic i_io_read,
  input wire logic i_io_write,
  input wire logic i_display_port_range_select,
  output logic o_display_port_hit,
  output logic o_display_port_is_3xx,
  input wire logic i_sysaddr_output_enable_n,
  output logic [2:0] o_plane3_addr_data,
  output logic o_plane3_addr_data_oe_n,
  input wire logic [7:0] i_local_data,
  output logic [7:0] o_local_data,
  output logic o_local_data_oe_n,
  input wire logic i_panel_type_select,
  input wire display_glue_pkg::video_bus_t i_video,
  input wire display_glue_pkg::panel_bus_t i_panel,
  input wire logic [2:0] i_panel_data,
  output logic [2:0] o_panel_data_n,
  output display_glue_pkg::video_bus_t o_shared_video,
  input wire logic i_sec_red_block,
  output logic o_secondary_red_enable,
  input wire logic i_trap_event,
  input wire logic i_nmi_timing,
  output logic o_trap_request_out,
  output logic o_nmi_timing_out
);

  // ----------------------------------------
  // port decode
  // ----------------------------------------
  // select names the range; a hit needs address bit 8 to match it
  function automatic logic [1:0] port_range(input logic sel);
    port_range = sel ? display_glue_pkg::PORT_HI_3XX : display_glue_pkg::PORT_HI_2XX;
  endfunction : port_range

  wire logic [1:0] want_hi = port_range(i_display_port_range_select);
  wire logic [1:0] addr_hi = i_sys_addr[display_glue_pkg::PORT_HI_MSB:display_glue_pkg::PORT_HI_LSB];
  wire logic upper_zero = ~|i_sys_addr[19:10];
  wire logic port_hit = upper_zero && (addr_hi == want_hi) && (i_io_read || i_io_write);
  wire logic drive_sys = port_hit && i_io_read;

  // ----------------------------------------
  // video routing
  // ----------------------------------------
  wire display_glue_pkg::route_t route_sel =
    i_panel_type_select ? display_glue_pkg::ROUTE_PANEL : display_glue_pkg::ROUTE_CRT;
  display_glue_pkg::route_t route_ff;
  display_glue_pkg::video_bus_t panel_map;
  assign panel_map.vsync = i_panel.vsync;
  assign panel_map.hsync = i_panel.hsync;
  assign panel_map.sec_blue = i_panel.data_1;
  assign panel_map.sec_green = i_panel.sel_4;
  assign panel_map.blue = i_panel.sel_3;
  assign panel_map.green = i_panel.sel_2;
  assign panel_map.red = i_panel.sel_1;
  assign panel_map.sec_red = 1'h0;
  wire display_glue_pkg::video_bus_t nxt_video =
    (route_ff == display_glue_pkg::ROUTE_PANEL) ? panel_map : i_video;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      route_ff <= display_glue_pkg::ROUTE_CRT;
      o_shared_video <= '0;
      o_secondary_red_enable <= display_glue_pkg::VIDEO_RST;
      o_panel_data_n <= {3{display_glue_pkg::PANEL_DATA_RST}};
    end else if (i_clk_en) begin
      route_ff <= route_sel;
      o_shared_video <= nxt_video;
      o_secondary_red_enable <= i_sec_red_block && (route_ff == display_glue_pkg::ROUTE_CRT);
      o_panel_data_n <= ~i_panel_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sys_data <= display_glue_pkg::DATA_RST;
      o_sys_data_oe_n <= 1'h1;
      o_local_data <= display_glue_pkg::DATA_RST;
      o_local_data_oe_n <= 1'h1;
      o_display_port_hit <= 1'h0;
      o_display_port_is_3xx <= 1'h0;
    end else if (i_clk_en) begin
      o_sys_data <= i_local_data;
      o_sys_data_oe_n <= ~drive_sys;
      o_local_data <= i_sys_data;
      o_local_data_oe_n <= ~(port_hit && i_io_write);
      o_display_port_hit <= port_hit;
      o_display_port_is_3xx <= port_hit && (want_hi == display_glue_pkg::PORT_HI_3XX);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_plane3_addr_data <= 3'h0;
      o_plane3_addr_data_oe_n <= 1'h1;
      o_trap_request_out <= 1'h0;
      o_nmi_timing_out <= 1'h0;
    end else if (i_clk_en) begin
      o_plane3_addr_data <= i_sys_addr[display_glue_pkg::PLANE3_ADDR_LSB +: 3];
      o_plane3_addr_data_oe_n <= i_sysaddr_output_enable_n;
      o_trap_request_out <= i_trap_event;
      o_nmi_timing_out <= i_nmi_timing;
    end
  end

endmodule : display_bus_interface_glue

// ==== logic/display_glue_pkg.sv ====
package display_glue_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int SYS_ADDR_W = 20;
  localparam int DATA_W = 8;

  // ----------------------------------------
  // decode positions and values
  // ----------------------------------------
  localparam int PORT_SEL_BIT = 8;
  localparam logic [1:0] PORT_HI_3XX = 2'h3;
  localparam logic [1:0] PORT_HI_2XX = 2'h2;
  localparam int PORT_HI_LSB = 8;
  localparam int PORT_HI_MSB = 9;
  localparam int PLANE3_ADDR_LSB = 6;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] PORT_RANGE_RST = 2'h0;
  localparam logic VIDEO_RST = 1'h0;
  localparam logic PANEL_DATA_RST = 1'h1;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic red;
    logic green;
    logic blue;
    logic sec_red;
    logic sec_green;
    logic sec_blue;
    logic vsync;
    logic hsync;
  } video_bus_t;

  typedef struct packed {
    logic vsync;
    logic hsync;
    logic data_1;
    logic sel_1;
    logic sel_2;
    logic sel_3;
    logic sel_4;
  } panel_bus_t;

  typedef enum logic {
    ROUTE_CRT,
    ROUTE_PANEL
  } route_t;

endpackage : display_glue_pkg

// ==== test/display_glue_props.sv ====
`timescale 1ns/1ps
module display_glue_props (
  input wire logic i_core_clk, i_rst_n, i_clk_en, i_io_read, i_display_port_range_select,
  input wire logic [19:0] i_sys_addr,
  input wire logic [7:0] i_local_data, o_sys_data,
  input wire logic o_display_port_hit, o_display_port_is_3xx, o_sys_data_oe_n, i_panel_type_select,
  input wire logic i_sysaddr_output_enable_n, o_plane3_addr_data_oe_n, i_trap_event, o_trap_request_out,
  input wire logic [2:0] o_plane3_addr_data, i_panel_data, o_panel_data_n,
  input wire display_glue_pkg::video_bus_t i_video, o_shared_video,
  input wire display_glue_pkg::panel_bus_t i_panel,
  input wire logic i_sec_red_block, o_secondary_red_enable
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire e = i_clk_en;
  wire s = i_panel_type_select;
  wire [11:0] hi = i_sys_addr[19:8];
  wire [2:0] p3 = i_sys_addr[8:6];
  wire [7:0] pm = {i_panel.sel_1, i_panel.sel_2, i_panel.sel_3, 1'b0, i_panel.sel_4, i_panel.data_1, i_panel.vsync,
    i_panel.hsync};
  AST_PANEL_N: assert property (e |=> o_panel_data_n == ~$past(i_panel_data))
    else $error("panel data polarity");
  AST_PLANE3: assert property (e |=> o_plane3_addr_data_oe_n == $past(i_sysaddr_output_enable_n) &&
    (o_plane3_addr_data_oe_n || o_plane3_addr_data == $past(p3))) else $error("plane3 drive");
  AST_HIT3: assert property (e && i_io_read && hi == 12'h003 && i_display_port_range_select |=>
    o_display_port_hit && o_display_port_is_3xx && !o_sys_data_oe_n && o_sys_data == $past(i_local_data))
    else $error("3xx read");
  AST_HIT2: assert property (e && i_io_read && hi == 12'h002 && !i_display_port_range_select |=>
    o_display_port_hit && !o_display_port_is_3xx) else $error("2xx read");
  AST_TRAP: assert property (e |=> o_trap_request_out == $past(i_trap_event)) else $error("trap");
  AST_CRT: assert property (e && !s ##1 e && !s |=> o_shared_video == $past(i_video)) else $error("crt");
  AST_PANEL: assert property (e && s ##1 e && s |=> o_shared_video == $past(pm)) else $error("panel");
  AST_SRED: assert property (e && !s ##1 e && !s |=> o_secondary_red_enable == $past(i_sec_red_block))
    else $error("sec red");
  cover property (e && i_io_read && hi == 12'h003);
  cover property (s ##1 s);
  cover property (!i_sysaddr_output_enable_n);
endmodule : display_glue_props
bind display_bus_interface_glue display_glue_props chk (.*);

// ==== test/display_glue_partner.sv ====
`timescale 1ns/1ps
module display_glue_partner (
  input wire logic i_core_clk,
  output logic [7:0] o_local_data,
  output display_glue_pkg::video_bus_t o_video,
  output display_glue_pkg::panel_bus_t o_panel
);
  logic [7:0] cnt_ff = 8'h00;
  always @(posedge i_core_clk) cnt_ff <= cnt_ff + 8'h01;
  // shared local bus never holds still
  assign o_local_data = cnt_ff ^ 8'hA5;
  assign o_video = cnt_ff;
  assign o_panel = cnt_ff[7:1] ^ 7'h2B;
endmodule : display_glue_partner

// ==== test/display_bus_interface_glue_test.sv ====
`timescale 1ns/1ps
module display_bus_interface_glue_test;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, rsel = 1'b0, aoe_n = 1'b1, psel = 1'b0, srb = 1'b0, trap_request_out = 1'b0;
  logic [19:0] addr = 20'h00000;
  logic [2:0] pd = 3'h0, p3, pdn;
  logic [7:0] ld, sdo, x;
  display_glue_pkg::video_bus_t vid, vout, v;
  display_glue_pkg::panel_bus_t pan, q;
  logic sd_oe_n, hit, h3, p3_oe_n, sre, trpo, nto, lo_oe_n, wr = 1'b0;
  logic [7:0] lo;
  int n_fail = 0, comparisons = 0, cyc = 0;
  always #2.5 clk = ~clk;
  display_glue_partner far (.i_core_clk(clk), .o_local_data(ld), .o_video(vid), .o_panel(pan));
  display_bus_interface_glue dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_sys_addr(addr),
    .i_sys_data(8'h5A), .o_sys_data(sdo), .o_sys_data_oe_n(sd_oe_n), .i_io_read(rd), .i_io_write(wr),
    .i_display_port_range_select(rsel), .o_display_port_hit(hit), .o_display_port_is_3xx(h3),
    .i_sysaddr_output_enable_n(aoe_n), .o_plane3_addr_data(p3), .o_plane3_addr_data_oe_n(p3_oe_n),
    .i_local_data(ld), .o_local_data(lo), .o_local_data_oe_n(lo_oe_n), .i_panel_type_select(psel), .i_video(vid),
    .i_panel(pan), .i_panel_data(pd), .o_panel_data_n(pdn), .o_shared_video(vout), .i_sec_red_block(srb),
    .o_secondary_red_enable(sre), .i_trap_event(trap_request_out), .i_nmi_timing(trap_request_out), .o_trap_request_out(trpo),
    .o_nmi_timing_out(nto));
  task chk(input logic [15:0] g, w);
    comparisons++;
    if (g !== w) begin
      n_fail++;
      $display("CHECK FAILED %0t %h %h", $time, g, w);
    end
  endtask : chk
  task io(input logic [19:0] a, input logic s, input logic [1:0] w);
    @(posedge clk);
    addr <= a;
    rsel <= s;
    rd <= 1'b1;
    #1 x = ld;
    @(posedge clk);
    #1 chk({hit, h3}, w);
    if (w[1]) chk({sd_oe_n, sdo}, {1'b0, x});
    $display("io done");
  endtask : io
  task pins;
    @(posedge clk);
    aoe_n <= 1'b0;
    addr <= 20'h00140;
    pd <= 3'h5;
    trap_request_out <= 1'b1;
    @(posedge clk);
    aoe_n <= 1'b1;
    #1 chk({p3_oe_n, p3, pdn, trpo, nto}, {1'b0, 3'h5, 3'h2, 2'h3});
    @(posedge clk);
    #1 chk(p3_oe_n, 1'b1);
    $display("pins done");
  endtask : pins
  task wr_io;
    @(posedge clk);
    addr <= 20'h003C0;
    rsel <= 1'b1;
    wr <= 1'b1;
    @(posedge clk);
    #1 chk({lo_oe_n, lo}, {1'b0, 8'h5A});
    @(posedge clk);
    wr <= 1'b0;
    $display("write done");
  endtask : wr_io
  task route(input logic s);
    @(posedge clk);
    psel <= s;
    srb <= 1'b1;
    repeat (3) @(posedge clk);
    #1 v = vid;
    q = pan;
    @(posedge clk);
    #1 chk(vout, s ? {q.sel_1, q.sel_2, q.sel_3, 1'b0, q.sel_4, q.data_1, q.vsync, q.hsync} : v);
    chk(sre, !s);
    $display("route done");
  endtask : route
  task conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == 400) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 chk({vout, pdn, sd_oe_n, p3_oe_n}, {8'h00, 3'h7, 2'h3});
    @(posedge clk);
    rst_n <= 1'b1;
    io(20'h003C0, 1'b1, 2'h3);
    io(20'h002C0, 1'b0, 2'h2);
    io(20'h003C0, 1'b0, 2'h0);
    io(20'h007C0, 1'b1, 2'h0);
    @(posedge clk);
    rd <= 1'b0;
    pins();
    wr_io();
    route(1'b1);
    route(1'b0);
    conclude();
  end
endmodule : display_bus_interface_glue_test
